// ===== verilog/i2m_pkg.sv
// constants and types for the two-wire bus master port
package i2m_pkg;
    // register indices; byte address is four times the index
    localparam int IDX_RCV = 32'h0000_0200;
    localparam int IDX_TRN = 32'h0000_0202;
    localparam int IDX_BRG = 32'h0000_0204;
    localparam int IDX_CON = 32'h0000_0206;
    localparam int IDX_STA = 32'h0000_0208;
    localparam int IDX_ADD = 32'h0000_020a;
    localparam logic [11:0] ADDR_RCV = 12'(4 * IDX_RCV);
    localparam logic [11:0] ADDR_TRN = 12'(4 * IDX_TRN);
    localparam logic [11:0] ADDR_BRG = 12'(4 * IDX_BRG);
    localparam logic [11:0] ADDR_CON = 12'(4 * IDX_CON);
    localparam logic [11:0] ADDR_STA = 12'(4 * IDX_STA);
    localparam logic [11:0] ADDR_ADD = 12'(4 * IDX_ADD);
    // reset values
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_TRN = 16'h00ff;
    localparam logic [15:0] RST_CON = 16'h1000;
    // control bit positions
    localparam int CON_EN = 15;
    localparam int CON_SIDL = 13;
    localparam int CON_ACKDT = 5;
    localparam int CON_ACKEN = 4;
    localparam int CON_RCEN = 3;
    localparam int CON_PEN = 2;
    localparam int CON_RSEN = 1;
    localparam int CON_SEN = 0;
    // status bit position written by software
    localparam int STA_BCL = 10;
    // request mask for control bits 4..0
    localparam logic [4:0] REQ_ALL = 5'h1f;
    localparam logic [4:0] REQ_START = 5'h03;
    localparam logic [4:0] REQ_STOP = 5'h04;
    localparam logic [4:0] REQ_RX = 5'h08;
    localparam logic [4:0] REQ_ACK = 5'h10;
    // index of the last bit per transfer
    localparam logic [3:0] LAST_TX = 4'h8;
    localparam logic [3:0] LAST_RX = 4'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0, ST_START = 4'h1, ST_RS_LO = 4'h2,
        ST_RS_HI = 4'h3, ST_STOP_LO = 4'h4, ST_STOP_HI = 4'h5,
        ST_STOP_REL = 4'h6, ST_BIT_LO = 4'h7, ST_BIT_HI = 4'h8
    } i2m_state_t;

    typedef enum logic [1:0] {
        K_TX = 2'h0, K_RX = 2'h1, K_ACK = 2'h2
    } i2m_kind_t;
endpackage : i2m_pkg

// ===== verilog/i2m_master.sv
// two-wire bus master: baud timing, arbitration, axi4-lite registers
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps

module i2m_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input logic mclk,
    input logic rst,
    input logic inValid,
    output logic inReady,
    input logic [W-1:0] inData,
    output logic outValid,
    input logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = count < (AW+1)'(D);
    assign outValid = count != '0;
    assign outData = mem[rdPtr];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= push ? AW'(wrPtr + 1'b1) : wrPtr;
            rdPtr <= pop ? AW'(rdPtr + 1'b1) : rdPtr;
            count <= (AW+1)'(count + push - pop);
        end
    end
endmodule : i2m_fifo

module i2m_master (
    input logic mclk,
    input logic rst,
    input logic [11:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [11:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input logic sleepReq,
    input logic cpuIdle,
    output logic masterEvent
);
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [31:0] d, input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge

    logic [1:0] sclSy;
    logic [1:0] sdaSy;
    logic sdaPrev;
    logic [15:0] ctrl, baud, txReg, ownAddr, baud_generator, next_brg;
    logic collision_status, sBit, pBit, transmit_buffer_full, lost;
    logic ackStat, next_ackStat, rxPush, next_rxPush;
    logic [7:0] shift, next_shift, rxData, next_rxData;
    logic [3:0] bitCnt, next_bitCnt;
    i2m_pkg::i2m_state_t state, next_state;
    i2m_pkg::i2m_kind_t kind, next_kind;
    logic sclLow, next_sclLow, sdaLow, next_sdaLow, done, next_done;
    logic [4:0] next_clr;
    logic awHeld, wHeld;
    logic [11:0] wAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic fifoReady, fifoValid;
    logic [7:0] fifoData;

    // pin synchronisers and bus condition detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            sclSy <= 2'h3;
            sdaSy <= 2'h3;
            sdaPrev <= 1'b1;
        end else begin
            sclSy <= {sclSy[0], sclIn};
            sdaSy <= {sdaSy[0], sdaIn};
            sdaPrev <= sdaSy[1];
        end
    end
    wire scl = sclSy[1];
    wire sda = sdaSy[1];
    wire busStart = scl && sdaPrev && !sda;
    wire busStop = scl && !sdaPrev && sda;

    wire abort = sleepReq || !ctrl[i2m_pkg::CON_EN];
    wire halt = abort || (cpuIdle && ctrl[i2m_pkg::CON_SIDL]);
    wire brgZero = baud_generator == 16'h0000;
    wire isIdle = state == i2m_pkg::ST_IDLE;
    wire hiPhase = state == i2m_pkg::ST_BIT_HI
        || state == i2m_pkg::ST_RS_HI || state == i2m_pkg::ST_STOP_HI;
    wire ackBit = kind == i2m_pkg::K_TX && bitCnt == i2m_pkg::LAST_TX;
    wire lastBit = ackBit || kind == i2m_pkg::K_ACK
        || (kind == i2m_pkg::K_RX && bitCnt == i2m_pkg::LAST_RX);
    wire bitDrive = kind == i2m_pkg::K_ACK ? !ctrl[i2m_pkg::CON_ACKDT]
        : (kind == i2m_pkg::K_TX && !bitCnt[3] && !shift[7]);
    wire expectOne = (state == i2m_pkg::ST_BIT_HI && !sdaLow
        && kind != i2m_pkg::K_RX && !ackBit)
        || state == i2m_pkg::ST_RS_HI || state == i2m_pkg::ST_STOP_REL;
    wire startBlocked = isIdle && ctrl[i2m_pkg::CON_SEN] && !(scl && sda);
    wire collide = !halt && ((expectOne && scl && !sda)
        || startBlocked);
    wire trStat = kind == i2m_pkg::K_TX
        && (state == i2m_pkg::ST_BIT_LO || state == i2m_pkg::ST_BIT_HI);

    always_comb begin
        next_state = state;
        next_brg = brgZero ? 16'h0000 : 16'(baud_generator - 16'h0001);
        next_bitCnt = bitCnt;
        next_kind = kind;
        next_shift = shift;
        next_sclLow = sclLow;
        next_sdaLow = sdaLow;
        next_done = 1'b0;
        next_clr = 5'h00;
        next_ackStat = ackStat;
        next_rxPush = 1'b0;
        next_rxData = rxData;
        if (abort) begin
            next_state = i2m_pkg::ST_IDLE;
            next_brg = 16'h0000;
            next_sclLow = 1'b0;
            next_sdaLow = 1'b0;
        end else if (halt) begin
            next_brg = baud_generator;
        end else if (collide) begin
            next_state = i2m_pkg::ST_IDLE;
            next_sclLow = 1'b0;
            next_sdaLow = 1'b0;
            next_clr = i2m_pkg::REQ_ALL;
        end else begin
            if (hiPhase && !scl) begin
                next_brg = baud;
            end
            case (state)
                i2m_pkg::ST_IDLE: begin
                    next_brg = baud;
                    next_sclLow = 1'b1;
                    next_bitCnt = 4'h0;
                    if (ctrl[i2m_pkg::CON_SEN]) begin
                        next_state = i2m_pkg::ST_START;
                        next_sclLow = sclLow;
                        next_sdaLow = 1'b1;
                    end else if (ctrl[i2m_pkg::CON_RSEN]) begin
                        next_state = i2m_pkg::ST_RS_LO;
                    end else if (ctrl[i2m_pkg::CON_PEN]) begin
                        next_state = i2m_pkg::ST_STOP_LO;
                    end else if (ctrl[i2m_pkg::CON_RCEN] && fifoReady) begin
                        next_state = i2m_pkg::ST_BIT_LO;
                        next_kind = i2m_pkg::K_RX;
                    end else if (ctrl[i2m_pkg::CON_ACKEN]) begin
                        next_state = i2m_pkg::ST_BIT_LO;
                        next_kind = i2m_pkg::K_ACK;
                    end else if (transmit_buffer_full) begin
                        next_state = i2m_pkg::ST_BIT_LO;
                        next_kind = i2m_pkg::K_TX;
                        next_shift = txReg[7:0];
                    end else begin
                        next_brg = baud_generator;
                        next_sclLow = sclLow;
                    end
                end
                i2m_pkg::ST_START: begin
                    if (brgZero) begin
                        next_state = i2m_pkg::ST_IDLE;
                        next_sclLow = 1'b1;
                        next_clr = i2m_pkg::REQ_START;
                        next_done = 1'b1;
                    end
                end
                i2m_pkg::ST_RS_LO: begin
                    next_sdaLow = 1'b0;
                    if (brgZero) begin
                        next_state = i2m_pkg::ST_RS_HI;
                        next_sclLow = 1'b0;
                        next_brg = baud;
                    end
                end
                i2m_pkg::ST_RS_HI: begin
                    if (scl && brgZero) begin
                        next_state = i2m_pkg::ST_START;
                        next_sdaLow = 1'b1;
                        next_brg = baud;
                    end
                end
                i2m_pkg::ST_STOP_LO: begin
                    next_sdaLow = 1'b1;
                    if (brgZero) begin
                        next_state = i2m_pkg::ST_STOP_HI;
                        next_sclLow = 1'b0;
                        next_brg = baud;
                    end
                end
                i2m_pkg::ST_STOP_HI: begin
                    if (scl && brgZero) begin
                        next_state = i2m_pkg::ST_STOP_REL;
                        next_sdaLow = 1'b0;
                        next_brg = baud;
                    end
                end
                i2m_pkg::ST_STOP_REL: begin
                    if (brgZero) begin
                        next_state = i2m_pkg::ST_IDLE;
                        next_clr = i2m_pkg::REQ_STOP;
                        next_done = 1'b1;
                    end
                end
                i2m_pkg::ST_BIT_LO: begin
                    next_sdaLow = bitDrive;
                    if (brgZero) begin
                        next_state = i2m_pkg::ST_BIT_HI;
                        next_sclLow = 1'b0;
                        next_brg = baud;
                    end
                end
                i2m_pkg::ST_BIT_HI: begin
                    if (scl && brgZero) begin
                        next_shift = {shift[6:0], sda};
                        next_bitCnt = 4'(bitCnt + 4'h1);
                        next_ackStat = ackBit ? sda : ackStat;
                        next_sclLow = 1'b1;
                        next_brg = baud;
                        next_state = i2m_pkg::ST_BIT_LO;
                        if (lastBit) begin
                            next_state = i2m_pkg::ST_IDLE;
                            next_done = 1'b1;
                            next_rxPush = kind == i2m_pkg::K_RX;
                            next_rxData = {shift[6:0], sda};
                            next_clr = kind == i2m_pkg::K_RX ? i2m_pkg::REQ_RX
                                : kind == i2m_pkg::K_ACK ? i2m_pkg::REQ_ACK
                                : 5'h00;
                        end
                    end
                end
                default: next_state = i2m_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= i2m_pkg::ST_IDLE;
            kind <= i2m_pkg::K_TX;
            baud_generator <= i2m_pkg::RST_ZERO;
            {bitCnt, shift, rxData} <= 20'h00000;
            {sclLow, sdaLow, done, ackStat, rxPush} <= 5'h00;
        end else begin
            state <= next_state;
            kind <= next_kind;
            baud_generator <= next_brg;
            {bitCnt, shift, rxData} <= {next_bitCnt, next_shift, next_rxData};
            {sclLow, sdaLow, done} <= {next_sclLow, next_sdaLow, next_done};
            {ackStat, rxPush} <= {next_ackStat, next_rxPush};
        end
    end

    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOe = sclLow;
    assign sdaOe = sdaLow;

    // register bus: write address and data latched in either order
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire wrFire = awHeld && wHeld;
    wire arFire = s_axi_arvalid && s_axi_arready;
    wire wTrn = wAddr[11:2] == i2m_pkg::ADDR_TRN[11:2];
    wire wBrg = wAddr[11:2] == i2m_pkg::ADDR_BRG[11:2];
    wire wCon = wAddr[11:2] == i2m_pkg::ADDR_CON[11:2];
    wire wSta = wAddr[11:2] == i2m_pkg::ADDR_STA[11:2];
    wire wAdd = wAddr[11:2] == i2m_pkg::ADDR_ADD[11:2];
    wire wRcv = wAddr[11:2] == i2m_pkg::ADDR_RCV[11:2];
    wire wHit = wTrn || wBrg || wCon || wSta || wAdd || wRcv;
    wire [9:0] rA = s_axi_araddr[11:2];
    wire rRcv = rA == i2m_pkg::ADDR_RCV[11:2];
    wire [15:0] status = {ackStat, trStat, 3'h0, collision_status, 5'h00,
        pBit, sBit, 1'b0, fifoValid, transmit_buffer_full};
    wire [15:0] rdMux = rRcv ? {8'h00, fifoData}
        : rA == i2m_pkg::ADDR_TRN[11:2] ? txReg
        : rA == i2m_pkg::ADDR_BRG[11:2] ? baud
        : rA == i2m_pkg::ADDR_CON[11:2] ? ctrl
        : rA == i2m_pkg::ADDR_STA[11:2] ? status
        : rA == i2m_pkg::ADDR_ADD[11:2] ? ownAddr : 16'h0000;
    wire rHit = rRcv || rA == i2m_pkg::ADDR_TRN[11:2]
        || rA == i2m_pkg::ADDR_BRG[11:2] || rA == i2m_pkg::ADDR_CON[11:2]
        || rA == i2m_pkg::ADDR_STA[11:2] || rA == i2m_pkg::ADDR_ADD[11:2];
    // request bits only take effect while the master waits
    wire [15:0] conWr = merge(ctrl, wData, wStrb);
    wire [15:0] conNew = isIdle ? conWr : {conWr[15:5], ctrl[4:0]};
    wire bclClr = wrFire && wSta && wStrb[1] && !wData[i2m_pkg::STA_BCL];

    always_ff @(posedge mclk) begin
        if (rst) begin
            {awHeld, wHeld, s_axi_bvalid, s_axi_rvalid} <= 4'h0;
            wAddr <= 12'h000;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            s_axi_bresp <= i2m_pkg::RESP_OKAY;
            s_axi_rresp <= i2m_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                wAddr <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeld <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeld <= 1'b0;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wHit ? i2m_pkg::RESP_OKAY
                    : i2m_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (arFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {16'h0000, rdMux};
                s_axi_rresp <= rHit ? i2m_pkg::RESP_OKAY
                    : i2m_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // software registers and hardware flags; hardware set wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= i2m_pkg::RST_CON;
            txReg <= i2m_pkg::RST_TRN;
            {baud, ownAddr} <= {i2m_pkg::RST_ZERO, i2m_pkg::RST_ZERO};
            {collision_status, sBit, pBit, transmit_buffer_full, lost, masterEvent} <= 6'h00;
        end else begin
            ctrl <= (wrFire && wCon ? conNew : ctrl) & ~{11'h000, next_clr};
            txReg <= wrFire && wTrn ? merge(txReg, wData, wStrb) : txReg;
            baud <= wrFire && wBrg ? merge(baud, wData, wStrb) : baud;
            ownAddr <= wrFire && wAdd ? merge(ownAddr, wData, wStrb) : ownAddr;
            transmit_buffer_full <= (wrFire && wTrn) || (transmit_buffer_full && !collide
                && !(next_done && kind == i2m_pkg::K_TX));
            collision_status <= collide || (collision_status && !bclClr);
            sBit <= busStart || (sBit && !busStop);
            pBit <= busStop || (pBit && !busStart);
            lost <= collide || (lost && !(isIdle && ctrl[i2m_pkg::CON_SEN]));
            masterEvent <= next_done || collide || (lost && busStop);
        end
    end

    i2m_fifo #(.W(8), .D(16)) rxFifo (
        .mclk(mclk),
        .rst(rst),
        .inValid(rxPush),
        .inReady(fifoReady),
        .inData(rxData),
        .outValid(fifoValid),
        .outReady(arFire && rRcv),
        .outData(fifoData)
    );

    property p_suspend;
        @(posedge mclk) disable iff (rst)
        (hiPhase && !scl && !halt && !collide) |=> baud_generator == $past(baud);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("baud counter ran while scl was low");
    property p_reload;
        @(posedge mclk) disable iff (rst)
        ($past(state) == i2m_pkg::ST_BIT_LO && state == i2m_pkg::ST_BIT_HI)
        |-> baud_generator == baud && !sclOe;
    endproperty
    a_reload: assert property (p_reload)
        else $error("high phase did not start from reload");
    property p_hold;
        @(posedge mclk) disable iff (rst)
        (brgZero && isIdle && ctrl[4:0] == 5'h00 && !transmit_buffer_full) |=> brgZero;
    endproperty
    a_hold: assert property (p_hold)
        else $error("idle baud counter left zero");
    property p_collide;
        @(posedge mclk) disable iff (rst)
        (!halt && expectOne && scl && !sda) |=> collision_status && isIdle;
    endproperty
    a_collide: assert property (p_collide)
        else $error("released one read as zero not flagged");
    property p_event;
        @(posedge mclk) disable iff (rst)
        collide |=> masterEvent ##1 !masterEvent || done || $past(busStop);
    endproperty
    a_event: assert property (p_event)
        else $error("collision did not pulse master event");
    property p_txabort;
        @(posedge mclk) disable iff (rst)
        (collide && trStat && !(wrFire && wTrn)) |=> !transmit_buffer_full && !sclOe && !sdaOe;
    endproperty
    a_txabort: assert property (p_txabort)
        else $error("byte collision left buffer full or lines held");
    property p_seqabort;
        @(posedge mclk) disable iff (rst)
        collide |=> ctrl[4:0] == 5'h00 && !sclOe && !sdaOe;
    endproperty
    a_seqabort: assert property (p_seqabort)
        else $error("collision kept a request bit or lines");
    property p_lost;
        @(posedge mclk) disable iff (rst)
        (lost && busStop) |=> masterEvent;
    endproperty
    a_lost: assert property (p_lost)
        else $error("bus stop after lost arbitration not signalled");
    property p_fresh;
        @(posedge mclk) disable iff (rst)
        (isIdle && next_state == i2m_pkg::ST_BIT_LO
        && next_kind == i2m_pkg::K_TX && !halt)
        |=> bitCnt == 4'h0 && shift == $past(txReg[7:0]);
    endproperty
    a_fresh: assert property (p_fresh)
        else $error("transmit did not start at first bit");
    property p_sleep;
        @(posedge mclk) disable iff (rst)
        sleepReq |=> isIdle && !sclOe && !sdaOe && brgZero;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep left transfer running");
    property p_idle;
        @(posedge mclk) disable iff (rst)
        (cpuIdle && ctrl[i2m_pkg::CON_SIDL] && !abort)
        |=> state == $past(state) && baud_generator == $past(baud_generator);
    endproperty
    a_idle: assert property (p_idle)
        else $error("module ran in cpu idle with stop-in-idle set");
    property p_sticky;
        @(posedge mclk) disable iff (rst)
        (collision_status && !bclClr) |=> collision_status;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("collision status dropped without software clear");
endmodule : i2m_master

// ===== verification/i2m_bus_model.sv
// far side of the bus: pull-ups, clock stretch, forced sda low
`timescale 1ns/1ps
module i2m_bus_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclOe,
    input wire logic sdaOe,
    input wire logic pullSda,
    output logic sclIn,
    output logic sdaIn
);
    logic [3:0] hold;
    // slow slave keeps scl low 8 cycles after the master lets go
    always_ff @(posedge mclk) begin
        hold <= (rst || sclOe) ? {!rst, 3'h0} : hold - {3'h0, |hold};
    end
    assign sclIn = !(sclOe || |hold);
    assign sdaIn = !(sdaOe || pullSda);
endmodule : i2m_bus_model

// ===== verification/i2m_master_tb.sv
// self-checking bench for the two-wire bus master port
`timescale 1ns/1ps
module i2m_master_tb;
    logic mclk = 0, rst = 1, pullSda = 0, sleepReq = 0, cpuIdle = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic sclIn, sclOe, sdaIn, sdaOe, masterEvent, sclOut, sdaOut;
    logic [15:0] d;
    int n_mismatch = 0, total_checks = 0;
    always #10 mclk = ~mclk;
    i2m_master u_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclIn, .sclOut,
        .sclOe, .sdaIn, .sdaOut, .sdaOe, .sleepReq, .cpuIdle,
        .masterEvent);
    i2m_bus_model u_bus (.mclk, .rst, .sclOe, .sdaOe, .pullSda, .sclIn,
        .sdaIn);
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic waitFor(ref logic s);
        int i = 0;
        do begin @(posedge mclk); i++; end while (i < 2000 && s !== 1'b1);
        if (s !== 1'b1) begin n_mismatch++; finish_test(); end
    endtask : waitFor
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        int i = 0;
        @(posedge mclk);
        s_axi_awaddr <= a; s_axi_wdata <= {16'h0, v}; s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge mclk); i++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (i < 50 && s_axi_bvalid !== 1'b1);
        if (s_axi_bvalid !== 1'b1) begin n_mismatch++; finish_test(); end
        r = s_axi_bresp; s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        int i = 0;
        @(posedge mclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge mclk); i++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (i < 50 && s_axi_rvalid !== 1'b1);
        if (s_axi_rvalid !== 1'b1) begin n_mismatch++; finish_test(); end
        d = s_axi_rdata[15:0]; r = s_axi_rresp; s_axi_rready <= 0;
    endtask : rd
    task automatic t_regs;
        rd(i2m_pkg::ADDR_CON); chk("ctrl", i2m_pkg::RST_CON, d);
        rd(i2m_pkg::ADDR_TRN); chk("trn", i2m_pkg::RST_TRN, d);
        rd(i2m_pkg::ADDR_BRG); chk("baud", i2m_pkg::RST_ZERO, d);
        rd(12'h004); chk("resp", {14'h0, i2m_pkg::RESP_SLVERR}, {14'h0, r});
    endtask : t_regs
    task automatic t_start;
        wr(i2m_pkg::ADDR_BRG, 16'h0004);
        chk("bresp", {14'h0, i2m_pkg::RESP_OKAY}, {14'h0, r});
        rd(i2m_pkg::ADDR_STA); chk("free", 16'h0000, d & 16'h0018);
        wr(i2m_pkg::ADDR_CON, 16'h8001);
        waitFor(masterEvent);
        @(posedge mclk); chk("sclOe", 16'h1, {15'h0, sclOe});
        chk("drive", 16'h0, {14'h0, sclOut, sdaOut});
        rd(i2m_pkg::ADDR_CON); chk("ctrl", 16'h8000, d);
        rd(i2m_pkg::ADDR_STA); chk("seen", 16'h0008, d & 16'h0018);
    endtask : t_start
    task automatic t_coll;
        pullSda <= 1;
        wr(i2m_pkg::ADDR_TRN, 16'h00ff);
        waitFor(masterEvent);
        @(posedge mclk); chk("lines", 16'h0, {14'h0, sclOe, sdaOe});
        rd(i2m_pkg::ADDR_STA); chk("coll", 16'h0400, d & 16'h0401);
        wr(i2m_pkg::ADDR_CON, 16'h8001);
        waitFor(masterEvent);
        rd(i2m_pkg::ADDR_CON); chk("req", 16'h8000, d);
        pullSda <= 0;
        waitFor(masterEvent);
        wr(i2m_pkg::ADDR_STA, 16'h0000);
        rd(i2m_pkg::ADDR_STA); chk("clr", 16'h0010, d & 16'h0418);
    endtask : t_coll
    task automatic t_sleep;
        wr(i2m_pkg::ADDR_CON, 16'ha001);
        sleepReq <= 1;
        repeat (3) @(posedge mclk);
        chk("sleep", 16'h0, {14'h0, sclOe, sdaOe});
        sleepReq <= 0;
        cpuIdle <= 1;
        repeat (3) @(posedge mclk);
        chk("halt", 16'h0, {14'h0, sclOe, sdaOe});
        cpuIdle <= 0;
        waitFor(masterEvent);
        rd(i2m_pkg::ADDR_CON); chk("resume", 16'ha000, d);
    endtask : t_sleep
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        t_regs();
        t_start();
        t_coll();
        t_sleep();
        finish_test();
    end
endmodule : i2m_master_tb
